// ==== logic/ddcnb_pkg.sv ====
`default_nettype none
// ==========================================================
// constants of the preset and binding register bank
package ddcnb_pkg;
	// register word indices, byte address is four times these
	localparam logic [9:0] IDX_MODE = 10'h214;
	localparam logic [9:0] IDX_SEL  = 10'h215;
	localparam logic [9:0] IDX_BIND = 10'h216;
	localparam logic [9:0] IDX_RDIV = 10'h217;
	localparam logic [9:0] IDX_STAT = 10'h21a;
	// reset values
	localparam logic [7:0]  RST_MODE = 8'h00;
	localparam logic [7:0]  RST_SEL  = 8'h00;
	localparam logic [7:0]  RST_BIND = 8'h02;
	localparam logic [15:0] RST_RDIV = 16'h0000;
	// field positions
	localparam int SEL_A_LSB  = 0;
	localparam int SEL_B_LSB  = 2;
	localparam int BIND_A_BIT = 0;
	localparam int BIND_B_BIT = 1;
	localparam int STAT_LINK  = 4;
	localparam int STAT_CAL   = 5;
	localparam int STAT_PD_A  = 6;
	localparam int STAT_PD_B  = 7;
	// preset source modes, 3 is reserved
	localparam logic [1:0] MODE_REG    = 2'h0;
	localparam logic [1:0] MODE_PINS   = 2'h1;
	localparam logic [1:0] MODE_PINS_A = 2'h2;
	// bus responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
`default_nettype wire

// ==== logic/ddcnb_top.sv ====
// Operation
// - mode 0 takes each converter's active preset from the select register fields.
// - mode 1 takes converter A's preset from pins A and converter B's from pins B.
// - mode 2 uses pins A for both converters; software never writes the reserved 3.
// - each converter has four presets of frequency and phase, the index picks one pair.
// - select bits 3-2 give converter B's preset while the mode is 0.
// - select bits 1-0 give converter A's preset index while the mode is 0.
// - binding bit 1 feeds digital channel B from ADC A at 0, ADC B at 1 (default).
// - binding bit 0 feeds digital channel A from ADC A at 0 (default), ADC B at 1.
// - a digital channel powers down when its bound ADC channel does.
// - one 16-bit rational reference divisor serves every preset.
// - the frequency word is 32 bits wide.
`timescale 1ns/100ps
`default_nettype none
module ddcnb_top #(
	parameter int ADDR_W  = 12,
	parameter int DATA_W  = 12,
	parameter int FREQ_W  = 32,
	parameter int PHASE_W = 16
) (
	// clock and reset
	input  wire logic                  clock,
	input  wire logic                  reset,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0]     s_axi_awaddr,
	input  wire logic [2:0]            s_axi_awprot,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0]     s_axi_araddr,
	input  wire logic [2:0]            s_axi_arprot,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready,
	// preset pins and device controls
	input  wire logic [1:0]            preset_pins_a,
	input  wire logic [1:0]            preset_pins_b,
	input  wire logic                  powerdown_adc_a,
	input  wire logic                  powerdown_adc_b,
	input  wire logic                  serial_link_enable,
	input  wire logic                  calibration_enable,
	// preset tables
	input  wire logic [3:0][FREQ_W-1:0]  freq_word_conv_a,
	input  wire logic [3:0][PHASE_W-1:0] phase_word_conv_a,
	input  wire logic [3:0][FREQ_W-1:0]  freq_word_conv_b,
	input  wire logic [3:0][PHASE_W-1:0] phase_word_conv_b,
	// adc samples
	input  wire logic [DATA_W-1:0]     adc_data_a,
	input  wire logic [DATA_W-1:0]     adc_data_b,
	// active nco settings
	output logic [1:0]                 active_preset_a,
	output logic [1:0]                 active_preset_b,
	output logic [FREQ_W-1:0]          active_freq_a,
	output logic [PHASE_W-1:0]         active_phase_a,
	output logic [FREQ_W-1:0]          active_freq_b,
	output logic [PHASE_W-1:0]         active_phase_b,
	output logic [15:0]                rational_ref_divisor,
	// digital channels
	output logic [DATA_W-1:0]          dig_data_a,
	output logic [DATA_W-1:0]          dig_data_b,
	output logic                       dig_powerdown_a,
	output logic                       dig_powerdown_b
);

	// ==========================================================
	// state
	typedef struct packed {
		logic [7:0]              mode;
		logic [7:0]              sel;
		logic [7:0]              binding;
		logic [15:0]             rdiv;
		logic                    aw_have;
		logic [ADDR_W-1:0]       aw_addr;
		logic                    w_have;
		logic [31:0]             w_data;
		logic [3:0]              w_strb;
		logic                    awready;
		logic                    wready;
		logic                    bvalid;
		logic [1:0]              bresp;
		logic                    arready;
		logic                    rvalid;
		logic [1:0]              rresp;
		logic [31:0]             rdata;
		logic [1:0]              preset_a;
		logic [1:0]              preset_b;
		logic [FREQ_W-1:0]       freq_a;
		logic [PHASE_W-1:0]      phase_a;
		logic [FREQ_W-1:0]       freq_b;
		logic [PHASE_W-1:0]      phase_b;
		logic [DATA_W-1:0]       data_a;
		logic [DATA_W-1:0]       data_b;
		logic                    pd_a;
		logic                    pd_b;
	} ddcnb_state_t;

	ddcnb_state_t s_q;
	ddcnb_state_t s_d;

	// ==========================================================
	// helpers
	// word index from a byte address, low two bits ignored
	function automatic logic [9:0] word_idx(input logic [ADDR_W-1:0] a);
		word_idx = a[11:2];
	endfunction

	function automatic logic mapped(input logic [9:0] i);
		mapped = (i == ddcnb_pkg::IDX_MODE) || (i == ddcnb_pkg::IDX_SEL) ||
			(i == ddcnb_pkg::IDX_BIND) || (i == ddcnb_pkg::IDX_RDIV) ||
			(i == ddcnb_pkg::IDX_STAT);
	endfunction

	// byte lane merge, reserved bits are stored like any other
	function automatic logic [7:0] lane(input logic [7:0] old, input logic [7:0] nw,
		input logic en);
		lane = en ? nw : old;
	endfunction

	// ==========================================================
	// next state
	always_comb begin
		logic [9:0] widx;
		logic [9:0] ridx;
		logic       ma;
		logic       mb;
		widx = word_idx(s_q.aw_addr);
		ridx = word_idx(s_axi_araddr);
		ma = 1'b0;
		mb = 1'b0;
		s_d = s_q;

		// write address and data are captured independently
		if (s_q.bvalid && s_axi_bready) begin
			s_d.bvalid = 1'b0;
		end
		if (s_axi_awvalid && s_q.awready) begin
			s_d.aw_have = 1'b1;
			s_d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_q.wready) begin
			s_d.w_have = 1'b1;
			s_d.w_data = s_axi_wdata;
			s_d.w_strb = s_axi_wstrb;
		end
		widx = word_idx(s_d.aw_addr);
		// commit once both halves are in and no response is pending
		if (s_d.aw_have && s_d.w_have && !s_d.bvalid) begin
			s_d.aw_have = 1'b0;
			s_d.w_have = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = mapped(widx) ? ddcnb_pkg::RESP_OKAY : ddcnb_pkg::RESP_SLVERR;
			case (widx)
				ddcnb_pkg::IDX_MODE: begin
					s_d.mode = lane(s_q.mode, s_d.w_data[7:0], s_d.w_strb[0]);
				end
				ddcnb_pkg::IDX_SEL: begin
					s_d.sel = lane(s_q.sel, s_d.w_data[7:0], s_d.w_strb[0]);
				end
				ddcnb_pkg::IDX_BIND: begin
					s_d.binding = lane(s_q.binding, s_d.w_data[7:0], s_d.w_strb[0]);
				end
				ddcnb_pkg::IDX_RDIV: begin
					s_d.rdiv[7:0] = lane(s_q.rdiv[7:0], s_d.w_data[7:0], s_d.w_strb[0]);
					s_d.rdiv[15:8] = lane(s_q.rdiv[15:8], s_d.w_data[15:8], s_d.w_strb[1]);
				end
				default: begin
				end
			endcase
		end
		// one write in flight at a time
		s_d.awready = !s_d.aw_have;
		s_d.wready = !s_d.w_have;

		// read channel, answer one cycle after the address is taken
		if (s_q.rvalid && s_axi_rready) begin
			s_d.rvalid = 1'b0;
		end
		if (s_axi_arvalid && s_q.arready) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = mapped(ridx) ? ddcnb_pkg::RESP_OKAY : ddcnb_pkg::RESP_SLVERR;
			s_d.rdata = 32'h0000_0000;
			case (ridx)
				ddcnb_pkg::IDX_MODE: s_d.rdata[7:0] = s_q.mode;
				ddcnb_pkg::IDX_SEL:  s_d.rdata[7:0] = s_q.sel;
				ddcnb_pkg::IDX_BIND: s_d.rdata[7:0] = s_q.binding;
				ddcnb_pkg::IDX_RDIV: s_d.rdata[15:0] = s_q.rdiv;
				ddcnb_pkg::IDX_STAT: begin
					s_d.rdata[1:0] = s_q.preset_a;
					s_d.rdata[3:2] = s_q.preset_b;
					s_d.rdata[ddcnb_pkg::STAT_LINK] = serial_link_enable;
					s_d.rdata[ddcnb_pkg::STAT_CAL] = calibration_enable;
					s_d.rdata[ddcnb_pkg::STAT_PD_A] = s_q.pd_a;
					s_d.rdata[ddcnb_pkg::STAT_PD_B] = s_q.pd_b;
				end
				default: begin
				end
			endcase
		end
		s_d.arready = !s_d.rvalid;

		// preset source, reserved mode 3 falls back to the register fields
		case (s_q.mode[1:0])
			ddcnb_pkg::MODE_PINS: begin
				s_d.preset_a = preset_pins_a;
				s_d.preset_b = preset_pins_b;
			end
			ddcnb_pkg::MODE_PINS_A: begin
				s_d.preset_a = preset_pins_a;
				s_d.preset_b = preset_pins_a;
			end
			default: begin
				s_d.preset_a = s_q.sel[ddcnb_pkg::SEL_A_LSB +: 2];
				s_d.preset_b = s_q.sel[ddcnb_pkg::SEL_B_LSB +: 2];
			end
		endcase

		// preset tables indexed by the new active preset
		s_d.freq_a = freq_word_conv_a[s_d.preset_a];
		s_d.phase_a = phase_word_conv_a[s_d.preset_a];
		s_d.freq_b = freq_word_conv_b[s_d.preset_b];
		s_d.phase_b = phase_word_conv_b[s_d.preset_b];

		// channel binding, reserved binding bits are ignored here
		ma = s_q.binding[ddcnb_pkg::BIND_A_BIT];
		mb = s_q.binding[ddcnb_pkg::BIND_B_BIT];
		s_d.data_a = ma ? adc_data_b : adc_data_a;
		s_d.data_b = mb ? adc_data_b : adc_data_a;
		s_d.pd_a = ma ? powerdown_adc_b : powerdown_adc_a;
		s_d.pd_b = mb ? powerdown_adc_b : powerdown_adc_a;
	end

	// ==========================================================
	// registers
	always_ff @(posedge clock) begin
		if (reset) begin
			s_q <= '0;
			s_q.mode <= ddcnb_pkg::RST_MODE;
			s_q.sel <= ddcnb_pkg::RST_SEL;
			s_q.binding <= ddcnb_pkg::RST_BIND;
			s_q.rdiv <= ddcnb_pkg::RST_RDIV;
		end else begin
			s_q <= s_d;
		end
	end

	// outputs straight from the state flops
	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = s_q.bresp;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rresp = s_q.rresp;
	assign s_axi_rdata = s_q.rdata;
	assign active_preset_a = s_q.preset_a;
	assign active_preset_b = s_q.preset_b;
	assign active_freq_a = s_q.freq_a;
	assign active_phase_a = s_q.phase_a;
	assign active_freq_b = s_q.freq_b;
	assign active_phase_b = s_q.phase_b;
	assign rational_ref_divisor = s_q.rdiv;
	assign dig_data_a = s_q.data_a;
	assign dig_data_b = s_q.data_b;
	assign dig_powerdown_a = s_q.pd_a;
	assign dig_powerdown_b = s_q.pd_b;

	// ==========================================================
	// checks, the mode 0 and binding antecedents skip the reset edge whose outputs still show reset values
	chk_mode_reg_a: assert property (@(posedge clock) disable iff (reset)
		!reset && s_q.mode[1:0] == ddcnb_pkg::MODE_REG |=>
		active_preset_a == $past(s_q.sel[1:0]))
		else $error("preset a not from select field");
	chk_pins_both: assert property (@(posedge clock) disable iff (reset)
		s_q.mode[1:0] == ddcnb_pkg::MODE_PINS |=>
		active_preset_a == $past(preset_pins_a) && active_preset_b == $past(preset_pins_b))
		else $error("presets not from own pins");
	chk_pins_a_shared: assert property (@(posedge clock) disable iff (reset)
		s_q.mode[1:0] == ddcnb_pkg::MODE_PINS_A |=> active_preset_b == $past(preset_pins_a))
		else $error("preset b not from pins a");
	chk_phase_pick: assert property (@(posedge clock) disable iff (reset)
		!reset && s_q.mode[1:0] == ddcnb_pkg::MODE_REG |=>
		active_phase_a == $past(phase_word_conv_a[s_q.sel[1:0]]))
		else $error("phase a not from selected preset");
	chk_sel_b_field: assert property (@(posedge clock) disable iff (reset)
		!reset && s_q.mode[1:0] == ddcnb_pkg::MODE_REG |=>
		active_preset_b == $past(s_q.sel[3:2]))
		else $error("preset b not from select bits 3-2");
	chk_bind_b: assert property (@(posedge clock) disable iff (reset)
		!reset |=>
		dig_data_b == ($past(s_q.binding[1]) ? $past(adc_data_b) : $past(adc_data_a)))
		else $error("digital b routed wrong");
	chk_bind_a: assert property (@(posedge clock) disable iff (reset)
		!reset && !s_q.binding[0] |=> dig_data_a == $past(adc_data_a))
		else $error("digital a routed wrong");
	chk_pd_follow: assert property (@(posedge clock) disable iff (reset)
		!reset |=> dig_powerdown_a ==
		($past(s_q.binding[0]) ? $past(powerdown_adc_b) : $past(powerdown_adc_a)))
		else $error("digital a not powered down");
	chk_bvalid_hold: assert property (@(posedge clock) disable iff (reset)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
endmodule
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb;
	// ==========================================================
	// stimulus and observed signals
	logic              clock = 1'b0;
	logic              reset = 1'b1;
	logic [11:0]       s_axi_awaddr = 12'h000;
	logic [11:0]       s_axi_araddr = 12'h000;
	logic [2:0]        s_axi_awprot = 3'h0;
	logic [2:0]        s_axi_arprot = 3'h0;
	logic [31:0]       s_axi_wdata = 32'h0;
	logic [3:0]        s_axi_wstrb = 4'h0;
	logic              s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic              s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic              s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]        s_axi_bresp, s_axi_rresp, active_preset_a, active_preset_b;
	logic [31:0]       s_axi_rdata, active_freq_a, active_freq_b;
	logic [15:0]       active_phase_a, active_phase_b, rational_ref_divisor;
	logic [1:0]        preset_pins_a = 2'h0, preset_pins_b = 2'h0;
	logic              powerdown_adc_a = 1'b0, powerdown_adc_b = 1'b0;
	logic              serial_link_enable = 1'b0, calibration_enable = 1'b0;
	logic [3:0][31:0]  freq_word_conv_a, freq_word_conv_b;
	logic [3:0][15:0]  phase_word_conv_a, phase_word_conv_b;
	logic [11:0]       adc_data_a = 12'h5a1, adc_data_b = 12'h3c2, dig_data_a, dig_data_b;
	logic              dig_powerdown_a, dig_powerdown_b;
	int                err_count = 0;
	int                n_compared = 0;

	// ==========================================================
	// design under test
	ddcnb_top dut (.clock, .reset, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .preset_pins_a, .preset_pins_b, .powerdown_adc_a, .powerdown_adc_b,
		.serial_link_enable, .calibration_enable, .freq_word_conv_a, .phase_word_conv_a,
		.freq_word_conv_b, .phase_word_conv_b, .adc_data_a, .adc_data_b, .active_preset_a,
		.active_preset_b, .active_freq_a, .active_phase_a, .active_freq_b, .active_phase_b,
		.rational_ref_divisor, .dig_data_a, .dig_data_b, .dig_powerdown_a, .dig_powerdown_b);

	// free-running 50 MHz clock
	always #10 clock = ~clock;

	// ==========================================================
	// table of ordinary cases
	typedef struct packed {
		logic [1:0] mode;
		logic [3:0] sel;
		logic [1:0] bnd;
		logic [1:0] pa;
		logic [1:0] pb;
		logic       pda;
		logic       pdb;
		logic [1:0] ea;
		logic [1:0] eb;
	} ddcnb_row_t;
	ddcnb_row_t rows [6] = '{
		'{2'h0, 4'h9, 2'h2, 2'h3, 2'h0, 1'b0, 1'b0, 2'h1, 2'h2},
		'{2'h0, 4'h7, 2'h0, 2'h0, 2'h2, 1'b1, 1'b0, 2'h3, 2'h1},
		'{2'h1, 4'h6, 2'h3, 2'h2, 2'h1, 1'b0, 1'b1, 2'h2, 2'h1},
		'{2'h1, 4'h0, 2'h1, 2'h0, 2'h3, 1'b1, 1'b0, 2'h0, 2'h3},
		'{2'h2, 4'h9, 2'h2, 2'h3, 2'h1, 1'b1, 1'b1, 2'h3, 2'h3},
		'{2'h2, 4'h0, 2'h2, 2'h1, 2'h2, 1'b0, 1'b0, 2'h1, 2'h1}};

	// ==========================================================
	// checking and closing
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// a wait that runs out is counted and ends the run
	task automatic timeout();
		err_count++;
		$display("FAIL t=%0t wait expired got=%h exp=%h", $time, 1'b0, 1'b1);
		print_verdict();
	endtask

	// ==========================================================
	// axi4-lite master: payload held until its own ready is seen
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		int n;
		// one edge between calls, so bready is never set twice in a step
		@(posedge clock);
		s_axi_awaddr  <= a;
		s_axi_wdata   <= d;
		s_axi_wstrb   <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid  <= 1'b1;
		s_axi_bready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		s_axi_bready <= 1'b0;
		if (n == 50) timeout();
		chk(32'(s_axi_bresp), 32'(er));
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		int n;
		@(posedge clock);
		s_axi_araddr  <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready  <= 1'b1;
		for (n = 0; n < 50; n++) begin
			@(posedge clock);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		s_axi_rready <= 1'b0;
		if (n == 50) timeout();
		chk(32'(s_axi_rresp), 32'(er));
		chk(s_axi_rdata, ed);
	endtask

	// ==========================================================
	// main sequence
	localparam logic [11:0] A_MODE = {ddcnb_pkg::IDX_MODE, 2'b00};
	localparam logic [11:0] A_SEL  = {ddcnb_pkg::IDX_SEL, 2'b00};
	localparam logic [11:0] A_BIND = {ddcnb_pkg::IDX_BIND, 2'b00};
	localparam logic [11:0] A_RDIV = {ddcnb_pkg::IDX_RDIV, 2'b00};
	localparam logic [1:0]  OK     = ddcnb_pkg::RESP_OKAY;
	initial begin
		for (int i = 0; i < 4; i++) begin
			freq_word_conv_a[i]  = 32'ha5000010 + 32'(i);
			freq_word_conv_b[i]  = 32'h3b000020 + 32'(i);
			phase_word_conv_a[i] = 16'h7100 + 16'(i);
			phase_word_conv_b[i] = 16'h8200 + 16'(i);
		end
		repeat (10) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(A_MODE, 32'h00, OK);
		rd(A_SEL, 32'h00, OK);
		rd(A_BIND, 32'h02, OK);
		rd(A_RDIV, 32'h0000, OK);
		// link and calibration stay off while the binding changes
		foreach (rows[i]) begin
			wr(A_MODE, 32'(rows[i].mode), 4'h1, OK);
			wr(A_SEL, 32'(rows[i].sel), 4'h1, OK);
			wr(A_BIND, 32'(rows[i].bnd), 4'h1, OK);
			preset_pins_a   <= rows[i].pa;
			preset_pins_b   <= rows[i].pb;
			powerdown_adc_a <= rows[i].pda;
			powerdown_adc_b <= rows[i].pdb;
			repeat (3) @(posedge clock);
			chk(32'(active_preset_a), 32'(rows[i].ea));
			chk(32'(active_preset_b), 32'(rows[i].eb));
			chk(active_freq_a, freq_word_conv_a[rows[i].ea]);
			chk(32'(active_phase_a), 32'(phase_word_conv_a[rows[i].ea]));
			chk(active_freq_b, freq_word_conv_b[rows[i].eb]);
			chk(32'(active_phase_b), 32'(phase_word_conv_b[rows[i].eb]));
			chk(32'(dig_data_a), 32'(rows[i].bnd[0] ? adc_data_b : adc_data_a));
			chk(32'(dig_data_b), 32'(rows[i].bnd[1] ? adc_data_b : adc_data_a));
			chk(32'(dig_powerdown_a), 32'(rows[i].bnd[0] ? rows[i].pdb : rows[i].pda));
			chk(32'(dig_powerdown_b), 32'(rows[i].bnd[1] ? rows[i].pdb : rows[i].pda));
		end
		// status word reports presets and enables
		serial_link_enable <= 1'b1;
		calibration_enable <= 1'b1;
		repeat (3) @(posedge clock);
		rd({ddcnb_pkg::IDX_STAT, 2'b00}, 32'h35, OK);
		// reserved bits stored but steering nothing
		wr(A_MODE, 32'hfc, 4'h1, OK);
		wr(A_SEL, 32'hf6, 4'h1, OK);
		rd(A_MODE, 32'hfc, OK);
		rd(A_SEL, 32'hf6, OK);
		repeat (3) @(posedge clock);
		chk(32'(active_preset_a), 32'h2);
		chk(32'(active_preset_b), 32'h1);
		// one divisor word, upper half reads zero
		wr(A_RDIV, 32'h1234beef, 4'hf, OK);
		rd(A_RDIV, 32'h0000beef, OK);
		chk(32'(rational_ref_divisor), 32'hbeef);
		// unmapped neighbour of the divisor
		rd(12'h860, 32'h0, ddcnb_pkg::RESP_SLVERR);
		wr(12'h860, 32'h55, 4'hf, ddcnb_pkg::RESP_SLVERR);
		// second reset in mid-run restores defaults
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		@(posedge clock);
		rd(A_BIND, 32'h02, OK);
		rd(A_SEL, 32'h00, OK);
		print_verdict();
	end
endmodule
`default_nettype wire
